// [frec_pkg.sv]
/*
 constants, register map and state type of the fault retry and
 emulation config block; assumes one 10 MHz clock and a same-clock
 register port from the serial management slave.
*/
// Notes on behaviour
// - recovery: check temp/backdrive, test current, switch, timer
// - expiry with low bus voltage restarts error handling
// - retry delay 15..50 ms, default 25 ms
// - recovery window 10..25 ms, default 20 ms
// - recovery voltage 250..1000 mV, default 750 mV
// - emulation succeeds when current exceeds threshold
// - charge threshold returns to default in sleep
// - other registers keep contents across sleep
// - thermal hold timer holds reduced limit
// - thermal hold 200/400/800/1600 ms
// - attach detection waits for settle timer
// - attach settle 200..1400, 2000 ms, default 800
// - dedicated profile off bit excludes profile
// - off bit ignored in dedicated charging mode
// - legacy bits remove profiles one to seven
// - retry register resets 2ah, settle register 03h
// - latch mode holds error until software clears
package frec_pkg;
    localparam logic [7:0] FAULT_RETRY_ADDR = 8'h1c;
    localparam logic [7:0] CHARGE_DETECT_ADDR = 8'h1e;
    localparam logic [7:0] THERMAL_ATTACH_ADDR = 8'h1f;
    localparam logic [7:0] DEDICATED_ADDR = 8'h20;
    localparam logic [7:0] LEGACY_ADDR = 8'h21;
    localparam logic [7:0] FAULT_RETRY_RESET = 8'h2a;
    localparam logic [7:0] CHARGE_DETECT_RESET = 8'h04;
    localparam logic [7:0] THERMAL_ATTACH_RESET = 8'h03;
    localparam logic [7:0] DEDICATED_RESET = 8'h06;
    localparam logic [7:0] LEGACY_RESET = 8'h00;
    localparam logic [7:0] FAULT_RETRY_MASK = 8'h7f;
    localparam logic [7:0] CHARGE_DETECT_MASK = 8'h0f;
    localparam logic [7:0] THERMAL_ATTACH_MASK = 8'h1f;
    localparam logic [7:0] DEDICATED_MASK = 8'h10;
    localparam logic [7:0] LEGACY_MASK = 8'h7f;
    localparam int RETRY_DELAY_LSB = 4;
    localparam int RECOVERY_WINDOW_LSB = 2;
    localparam int RECOVERY_VOLTAGE_LSB = 0;
    localparam int THERMAL_HOLD_LSB = 3;
    localparam int ATTACH_SETTLE_LSB = 0;
    localparam int DEDICATED_OFF_BIT = 4;
    localparam int RETRY_DELAY_BASE_MS = 15;
    localparam int RETRY_DELAY_STEP_MS = 5;
    localparam int RECOVERY_WINDOW_BASE_MS = 10;
    localparam int RECOVERY_WINDOW_STEP_MS = 5;
    localparam int RECOVERY_VOLTAGE_STEP_MV = 250;
    localparam int THERMAL_HOLD_BASE_MS = 200;
    localparam int ATTACH_SETTLE_STEP_MS = 200;
    localparam int ATTACH_SETTLE_MAX_MS = 2000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_PERIOD_NS = 1000000;
    localparam int MS_TICK_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
    typedef enum logic [1:0] {
        FAULT_IDLE, FAULT_ERROR, FAULT_CHECK, FAULT_TEST
    } frec_fault_state_t;
    function automatic logic [10:0] retryDelayMs(input logic [2:0] s);
        return 11'(RETRY_DELAY_BASE_MS + RETRY_DELAY_STEP_MS * int'(s));
    endfunction
    function automatic logic [10:0] windowMs(input logic [1:0] s);
        return 11'(RECOVERY_WINDOW_BASE_MS
            + RECOVERY_WINDOW_STEP_MS * int'(s));
    endfunction
    function automatic logic [10:0] voltageMv(input logic [1:0] s);
        return 11'((int'(s) + 1) * RECOVERY_VOLTAGE_STEP_MV);
    endfunction
    function automatic logic [10:0] thermalMs(input logic [1:0] s);
        return 11'(THERMAL_HOLD_BASE_MS << s);
    endfunction
    function automatic logic [10:0] settleMs(input logic [2:0] s);
        if (s == 3'h7) begin
            return 11'(ATTACH_SETTLE_MAX_MS);
        end
        return 11'((int'(s) + 1) * ATTACH_SETTLE_STEP_MS);
    endfunction
endpackage

// [frec_top.sv]
/*
 fault retry timing, recovery sequencer, thermal hold and attach
 settle timers, charge detect compare and profile enables; assumes
 the register port and analog measurements share ref_clk, mode
 select pins are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module frec_ms_timer (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic tick,
    input wire logic [10:0] loadMs,
    output logic running_q,
    output logic expire_q
);
    logic [10:0] count_q;
    // restart wins over a coinciding expiry
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            count_q <= 11'h000;
            running_q <= 1'b0;
            expire_q <= 1'b0;
        end else begin
            expire_q <= !start && tick && running_q && count_q == 11'h001;
            if (start) begin
                count_q <= loadMs;
                running_q <= loadMs != 11'h000;
            end else if (tick && running_q) begin
                count_q <= count_q - 11'h001;
                running_q <= count_q != 11'h001;
            end
        end
    end
endmodule
////////////////////////////////////////////////////////////////////////
module frec_top #(
    parameter int TICK_CYCLES = frec_pkg::MS_TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData_q,
    input wire logic sleepState,
    input wire logic latchMode,
    input wire logic faultDetected,
    input wire logic errClear,
    input wire logic overTemp,
    input wire logic backDrive,
    input wire logic [10:0] vbusMv,
    input wire logic [7:0] busCurrent,
    input wire logic tempOverReg,
    input wire logic bypassReactivated,
    input wire logic modeSelectA,
    input wire logic modeSelectB,
    input wire logic emulationEnable,
    output logic errorState_q,
    output logic testCurrentOn_q,
    output logic portSwitchOn_q,
    output logic shortDetected_q,
    output logic thermalHold_q,
    output logic attachEvalEnable_q,
    output logic emulationOk_q,
    output logic dedicatedProfileEn_q,
    output logic [6:0] legacyProfileEn_q
);
    if (TICK_CYCLES < 2 || TICK_CYCLES > 16384) begin : gBadTick
        $error("TICK_CYCLES out of range");
    end
    logic [7:0] retryReg_q, chargeReg_q, timeReg_q, dedReg_q, legReg_q;
    logic [13:0] tickCount_q;
    logic tick_q;
    logic [1:0] modeA_q, modeB_q;
    frec_pkg::frec_fault_state_t state_q, state_d;
    logic faultStart, faultRunning, faultExpire;
    logic [10:0] faultLoadMs, thresholdMv;
    logic thermalRunning, attachRunning, dcpMode;
    logic [2:0] retrySel, settleSel;
    logic [1:0] windowSel, voltSel, thermalSel;
    ////////////////////////////////////////////////////////////////////
    // register port; sleep resets only the charge threshold, to its 04h default
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            retryReg_q <= frec_pkg::FAULT_RETRY_RESET;
            timeReg_q <= frec_pkg::THERMAL_ATTACH_RESET;
            dedReg_q <= frec_pkg::DEDICATED_RESET;
            legReg_q <= frec_pkg::LEGACY_RESET;
        end else if (regWrEn) begin
            if (regAddr == frec_pkg::FAULT_RETRY_ADDR) begin
                retryReg_q <= regWrData & frec_pkg::FAULT_RETRY_MASK;
            end else if (regAddr == frec_pkg::THERMAL_ATTACH_ADDR) begin
                timeReg_q <= regWrData & frec_pkg::THERMAL_ATTACH_MASK;
            end else if (regAddr == frec_pkg::DEDICATED_ADDR) begin
                // reserved bits stay fixed whatever is written
                dedReg_q <= (regWrData & frec_pkg::DEDICATED_MASK)
                    | frec_pkg::DEDICATED_RESET;
            end else if (regAddr == frec_pkg::LEGACY_ADDR) begin
                legReg_q <= regWrData & frec_pkg::LEGACY_MASK;
            end
        end
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            chargeReg_q <= frec_pkg::CHARGE_DETECT_RESET;
        end else if (sleepState) begin
            chargeReg_q <= frec_pkg::CHARGE_DETECT_RESET;
        end else if (regWrEn && regAddr == frec_pkg::CHARGE_DETECT_ADDR) begin
            chargeReg_q <= regWrData & frec_pkg::CHARGE_DETECT_MASK;
        end
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            regRdData_q <= 8'h00;
        end else if (regRdEn) begin
            if (regAddr == frec_pkg::FAULT_RETRY_ADDR) begin
                regRdData_q <= retryReg_q;
            end else if (regAddr == frec_pkg::CHARGE_DETECT_ADDR) begin
                regRdData_q <= chargeReg_q;
            end else if (regAddr == frec_pkg::THERMAL_ATTACH_ADDR) begin
                regRdData_q <= timeReg_q;
            end else if (regAddr == frec_pkg::DEDICATED_ADDR) begin
                regRdData_q <= dedReg_q;
            end else if (regAddr == frec_pkg::LEGACY_ADDR) begin
                regRdData_q <= legReg_q;
            end else begin
                regRdData_q <= 8'h00;
            end
        end
    end
    assign retrySel = retryReg_q[frec_pkg::RETRY_DELAY_LSB +: 3];
    assign windowSel = retryReg_q[frec_pkg::RECOVERY_WINDOW_LSB +: 2];
    assign voltSel = retryReg_q[frec_pkg::RECOVERY_VOLTAGE_LSB +: 2];
    assign thermalSel = timeReg_q[frec_pkg::THERMAL_HOLD_LSB +: 2];
    assign settleSel = timeReg_q[frec_pkg::ATTACH_SETTLE_LSB +: 3];
    assign thresholdMv = frec_pkg::voltageMv(voltSel);
    ////////////////////////////////////////////////////////////////////
    // ms tick is free-running; the first ms after a start may be as short as one cycle
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tickCount_q <= 14'h0000;
            tick_q <= 1'b0;
        end else begin
            tick_q <= tickCount_q == 14'(TICK_CYCLES - 1);
            if (tickCount_q == 14'(TICK_CYCLES - 1)) begin
                tickCount_q <= 14'h0000;
            end else begin
                tickCount_q <= tickCount_q + 14'h0001;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////
    // fault sequencer; one timer serves delay and test window in turn
    always_comb begin
        state_d = state_q;
        faultStart = 1'b0;
        faultLoadMs = frec_pkg::retryDelayMs(retrySel);
        case (state_q)
            frec_pkg::FAULT_IDLE: begin
                if (faultDetected) begin
                    state_d = frec_pkg::FAULT_ERROR;
                    faultStart = 1'b1;
                end
            end
            frec_pkg::FAULT_ERROR: begin
                if (latchMode) begin
                    if (errClear) begin
                        state_d = frec_pkg::FAULT_IDLE;
                    end
                end else if (faultExpire) begin
                    state_d = frec_pkg::FAULT_CHECK;
                end
            end
            frec_pkg::FAULT_CHECK: begin
                faultStart = 1'b1;
                if (!overTemp && !backDrive) begin
                    state_d = frec_pkg::FAULT_TEST;
                    faultLoadMs = frec_pkg::windowMs(windowSel);
                end else begin
                    state_d = frec_pkg::FAULT_ERROR;
                end
            end
            frec_pkg::FAULT_TEST: begin
                if (faultExpire) begin
                    if (vbusMv < thresholdMv) begin
                        state_d = frec_pkg::FAULT_ERROR;
                        faultStart = 1'b1;
                    end else begin
                        state_d = frec_pkg::FAULT_IDLE;
                    end
                end
            end
            default: state_d = frec_pkg::FAULT_IDLE;
        endcase
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= frec_pkg::FAULT_IDLE;
            errorState_q <= 1'b0;
            testCurrentOn_q <= 1'b0;
            portSwitchOn_q <= 1'b0;
            shortDetected_q <= 1'b0;
        end else begin
            state_q <= state_d;
            errorState_q <= state_d == frec_pkg::FAULT_ERROR
                || state_d == frec_pkg::FAULT_CHECK;
            testCurrentOn_q <= state_d == frec_pkg::FAULT_TEST;
            portSwitchOn_q <= state_d == frec_pkg::FAULT_TEST
                || state_d == frec_pkg::FAULT_IDLE;
            shortDetected_q <= state_q == frec_pkg::FAULT_TEST
                && state_d == frec_pkg::FAULT_ERROR;
        end
    end
    frec_ms_timer uFaultTimer (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .start(faultStart),
        .tick(tick_q),
        .loadMs(faultLoadMs),
        .running_q(faultRunning),
        .expire_q(faultExpire)
    );
    ////////////////////////////////////////////////////////////////////
    // thermal hold and attach settle
    frec_ms_timer uThermalTimer (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .start(tempOverReg),
        .tick(tick_q),
        .loadMs(frec_pkg::thermalMs(thermalSel)),
        .running_q(thermalRunning),
        .expire_q()
    );
    frec_ms_timer uAttachTimer (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .start(bypassReactivated),
        .tick(tick_q),
        .loadMs(frec_pkg::settleMs(settleSel)),
        .running_q(attachRunning),
        .expire_q()
    );
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            thermalHold_q <= 1'b0;
            attachEvalEnable_q <= 1'b1;
        end else begin
            thermalHold_q <= thermalRunning || tempOverReg;
            attachEvalEnable_q <= !attachRunning
                && !bypassReactivated;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // emulation outcome and profile enables; mode pins synchronised
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            modeA_q <= 2'h0;
            modeB_q <= 2'h0;
        end else begin
            modeA_q <= {modeA_q[0], modeSelectA};
            modeB_q <= {modeB_q[0], modeSelectB};
        end
    end
    assign dcpMode = emulationEnable && modeA_q[1] && !modeB_q[1];
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            emulationOk_q <= 1'b0;
            dedicatedProfileEn_q <= 1'b1;
            legacyProfileEn_q <= 7'h7f;
        end else begin
            emulationOk_q <= busCurrent > chargeReg_q;
            dedicatedProfileEn_q <= dcpMode
                || !dedReg_q[frec_pkg::DEDICATED_OFF_BIT];
            legacyProfileEn_q <= ~legReg_q[6:0];
        end
    end
    ////////////////////////////////////////////////////////////////////
    sequence sTestEnd;
        state_q == frec_pkg::FAULT_TEST && faultExpire;
    endsequence
    chk_check_gate: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        state_q == frec_pkg::FAULT_CHECK && (overTemp || backDrive)
        |=> !testCurrentOn_q && state_q == frec_pkg::FAULT_ERROR)
        else $error("recovery entered despite temperature or backdrive");
    chk_short_restart: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        sTestEnd and vbusMv < thresholdMv
        |=> shortDetected_q && errorState_q && !portSwitchOn_q)
        else $error("short circuit not restarting error handling");
    chk_retry_load: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        faultStart && state_d == frec_pkg::FAULT_ERROR
        |-> faultLoadMs == 11'(15 + 5 * int'(retrySel)))
        else $error("retry delay load wrong");
    chk_window_load: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        faultStart && state_d == frec_pkg::FAULT_TEST
        |-> faultLoadMs == 11'(10 + 5 * int'(windowSel)))
        else $error("recovery window load wrong");
    chk_sleep_charge: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        sleepState |=> chargeReg_q == 8'h04)
        else $error("charge threshold kept in sleep");
    chk_sleep_keep: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        sleepState && !regWrEn |=> $stable(retryReg_q) && $stable(legReg_q))
        else $error("retained register changed in sleep");
    chk_emul_ok: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        (busCurrent > chargeReg_q && !sleepState && !regWrEn)[*2]
        |-> emulationOk_q)
        else $error("emulation success not flagged");
    chk_thermal_hold: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        tempOverReg |=> thermalHold_q [*2])
        else $error("thermal hold not held");
    chk_attach_wait: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        bypassReactivated |=> !attachEvalEnable_q ##1 !attachEvalEnable_q)
        else $error("attach evaluated before settle");
    chk_latch_hold: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        state_q == frec_pkg::FAULT_ERROR && latchMode && !errClear
        |=> state_q == frec_pkg::FAULT_ERROR)
        else $error("latched error left without clear");
    chk_dcp_force: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        dcpMode |=> dedicatedProfileEn_q)
        else $error("dedicated profile dropped in dedicated mode");
    chk_legacy_map: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        regWrEn && regAddr == 8'h21 ##2 1'b1
        |-> legacyProfileEn_q == ~$past(regWrData[6:0], 2))
        else $error("legacy enable mapping wrong");
    chk_check_pass: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        state_q == frec_pkg::FAULT_CHECK && !overTemp && !backDrive
        |=> testCurrentOn_q && portSwitchOn_q
            && state_q == frec_pkg::FAULT_TEST)
        else $error("recovery test not started after clean check");
    chk_test_power: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        testCurrentOn_q |-> portSwitchOn_q && !errorState_q)
        else $error("test current without port switch");
    chk_good_vbus: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        sTestEnd and vbusMv >= thresholdMv
        |=> !shortDetected_q && state_q == frec_pkg::FAULT_IDLE)
        else $error("healthy bus treated as short");
    chk_profile_off: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        !dcpMode && dedReg_q[frec_pkg::DEDICATED_OFF_BIT]
        |=> !dedicatedProfileEn_q)
        else $error("dedicated profile kept while switched off");
endmodule
`default_nettype wire

// [frec_port_load.sv]
/*
 port load model: the attached portable device, seen as bus voltage
 and drawn current; assumes the bench picks a shorted or healthy load.
*/
`timescale 1ns/1ps
`default_nettype none
module frec_port_load (
    input wire logic ref_clk,
    input wire logic shorted,
    input wire logic [7:0] drawCode,
    output logic [10:0] vbusMv,
    output logic [7:0] busCurrent
);
    // a short sits under the 500 mV test level, a healthy load far above
    always @(posedge ref_clk) begin
        vbusMv <= shorted ? 11'h190 : 11'h7d0;
        busCurrent <= drawCode;
    end
endmodule
`default_nettype wire

// [frec_top_test.sv]
/*
 self-checking bench for frec_top: register port reads and writes,
 sleep, fault retry, latch mode and ms timers; assumes the design
 runs with a short ms tick.
*/
`timescale 1ns/1ps
`default_nettype none
module frec_top_test;
    localparam int TICK = 4;
    logic ref_clk = 1'b0, resetn = 1'b0;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, drawCode = 8'h00;
    logic regWrEn = 1'b0, regRdEn = 1'b0, sleepState = 1'b0;
    logic latchMode = 1'b0, faultDetected = 1'b0, errClear = 1'b0;
    logic overTemp = 1'b0, backDrive = 1'b0, tempOverReg = 1'b0;
    logic bypassReactivated = 1'b0, modeSelectA = 1'b0;
    logic modeSelectB = 1'b0, emulationEnable = 1'b0, shorted = 1'b0;
    wire logic [10:0] vbusMv;
    wire logic [7:0] busCurrent, regRdData_q;
    wire logic errorState_q, testCurrentOn_q, portSwitchOn_q;
    wire logic shortDetected_q, thermalHold_q, attachEvalEnable_q;
    wire logic emulationOk_q, dedicatedProfileEn_q;
    wire logic [6:0] legacyProfileEn_q;
    int errTotal = 0, nCompared = 0;
    ////////////////////////////////////////////////////////////////////
    frec_top #(.TICK_CYCLES(TICK)) dut_u (.ref_clk(ref_clk),
        .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData_q(regRdData_q),
        .sleepState(sleepState), .latchMode(latchMode),
        .faultDetected(faultDetected), .errClear(errClear),
        .overTemp(overTemp), .backDrive(backDrive), .vbusMv(vbusMv),
        .busCurrent(busCurrent), .tempOverReg(tempOverReg),
        .bypassReactivated(bypassReactivated), .modeSelectA(modeSelectA),
        .modeSelectB(modeSelectB), .emulationEnable(emulationEnable),
        .errorState_q(errorState_q), .testCurrentOn_q(testCurrentOn_q),
        .portSwitchOn_q(portSwitchOn_q), .shortDetected_q(shortDetected_q),
        .thermalHold_q(thermalHold_q),
        .attachEvalEnable_q(attachEvalEnable_q),
        .emulationOk_q(emulationOk_q),
        .dedicatedProfileEn_q(dedicatedProfileEn_q),
        .legacyProfileEn_q(legacyProfileEn_q));
    frec_port_load load_u (.ref_clk(ref_clk), .shorted(shorted),
        .drawCode(drawCode), .vbusMv(vbusMv), .busCurrent(busCurrent));
    ////////////////////////////////////////////////////////////////////
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic chk(input string what, input logic [10:0] exp,
        input logic [10:0] got);
        nCompared++;
        if (got !== exp) begin
            errTotal++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chkRange(input string what, input int lo, input int hi,
        input int got);
        nCompared++;
        if (got < lo || got > hi) begin
            errTotal++;
            $display("wrong value %s expected %0d to %0d seen %0d", what,
                lo, hi, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #10;
    endtask
    task automatic pulse(ref logic s);
        cyc(1);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc(1);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        cyc(1);
        regWrEn = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        cyc(1);
        regAddr = a;
        regRdEn = 1'b1;
        cyc(1);
        regRdEn = 1'b0;
        chk("regRdData", 11'(exp), 11'(regRdData_q));
    endtask
    // one fault, retry delay 15 ms and window 10 ms from register 1c = 01
    task automatic runFault(input logic sh);
        int n;
        logic seen;
        n = 0;
        seen = 1'b0;
        shorted = sh;
        pulse(faultDetected);
        chk("errorState", 11'h1, 11'(errorState_q));
        chk("portSwitchOff", 11'h0, 11'(portSwitchOn_q));
        while (testCurrentOn_q !== 1'b1 && n < 300) begin
            cyc(1);
            n++;
        end
        chkRange("retryDelay", 14 * TICK, 15 * TICK + 4, n);
        chk("portSwitchOn", 11'h1, 11'(portSwitchOn_q));
        n = 0;
        while (testCurrentOn_q === 1'b1 && n < 300) begin
            cyc(1);
            n++;
            seen |= shortDetected_q;
        end
        cyc(1);
        seen |= shortDetected_q;
        chkRange("window", 9 * TICK, 10 * TICK + 4, n);
        chk("shortSeen", 11'(sh), 11'(seen));
        chk("errorAfter", 11'(sh), 11'(errorState_q));
    endtask
    task automatic tallyAndFinish;
        $display("compared %0d mismatches %0d", nCompared, errTotal);
        if (errTotal == 0 && nCompared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    localparam logic [7:0] ADR[6] = '{8'h1c, 8'h1e, 8'h1f, 8'h20, 8'h21,
        8'h22};
    localparam logic [7:0] RST[6] = '{8'h2a, 8'h04, 8'h03, 8'h06, 8'h00,
        8'h00};
    // reserved bits of 20 written as they read, so all-ones is 16
    // settle field of 1f kept at 800 ms, inside the software limit
    localparam logic [7:0] WRV[6] = '{8'hff, 8'hff, 8'hfb, 8'h16, 8'hff,
        8'hff};
    localparam logic [7:0] RBK[6] = '{8'h7f, 8'h0f, 8'h1b, 8'h16, 8'h7f,
        8'h00};
    initial begin
        int nT;
        int nA;
        int nG;
        nT = 0;
        nA = 0;
        nG = 0;
        cyc(2);
        resetn = 1'b1;
        chk("dedicatedEn", 11'h1, 11'(dedicatedProfileEn_q));
        chk("legacyEn", 11'h7f, 11'(legacyProfileEn_q));
        for (int i = 0; i < 6; i++) rd(ADR[i], RST[i]);
        for (int i = 0; i < 6; i++) wr(ADR[i], WRV[i]);
        for (int i = 0; i < 6; i++) rd(ADR[i], RBK[i]);
        wr(8'h21, 8'h05);
        cyc(2);
        chk("legacyEn", 11'h7a, 11'(legacyProfileEn_q));
        chk("dedicatedOff", 11'h0, 11'(dedicatedProfileEn_q));
        modeSelectA = 1'b1;
        emulationEnable = 1'b1;
        cyc(4);
        chk("dedicatedMode", 11'h1, 11'(dedicatedProfileEn_q));
        modeSelectB = 1'b1;
        cyc(4);
        chk("otherMode", 11'h0, 11'(dedicatedProfileEn_q));
        modeSelectA = 1'b0;
        modeSelectB = 1'b0;
        wr(8'h1e, 8'h0a);
        wr(8'h1c, 8'h01);
        sleepState = 1'b1;
        cyc(2);
        sleepState = 1'b0;
        rd(8'h1e, 8'h04);
        rd(8'h1c, 8'h01);
        rd(8'h21, 8'h05);
        drawCode = 8'h04;
        cyc(3);
        chk("emulationOk", 11'h0, 11'(emulationOk_q));
        drawCode = 8'h05;
        cyc(3);
        chk("emulationOk", 11'h1, 11'(emulationOk_q));
        runFault(1'b1);
        shorted = 1'b0;
        for (int i = 0; i < 300 && (errorState_q !== 1'b0
            || testCurrentOn_q !== 1'b0); i++) cyc(1);
        runFault(1'b0);
        // failing checks send the sequencer back to error each time
        overTemp = 1'b1;
        pulse(faultDetected);
        for (int i = 0; i < 150; i++) begin
            if (i == 75) begin
                overTemp = 1'b0;
                backDrive = 1'b1;
            end
            nG += (testCurrentOn_q !== 1'b0
                || errorState_q !== 1'b1) ? 1 : 0;
            cyc(1);
        end
        chk("checkGate", 11'h0, 11'(nG));
        backDrive = 1'b0;
        for (int i = 0; i < 300 && (errorState_q !== 1'b0
            || testCurrentOn_q !== 1'b0); i++) cyc(1);
        chk("recovered", 11'h0, 11'(errorState_q));
        latchMode = 1'b1;
        pulse(faultDetected);
        cyc(100);
        chk("latchedError", 11'h1, 11'(errorState_q));
        pulse(errClear);
        cyc(2);
        chk("latchCleared", 11'h0, 11'(errorState_q));
        latchMode = 1'b0;
        // 400 ms hold, 400 ms settle: within the 800 ms software limit
        wr(8'h1f, 8'h09);
        cyc(1);
        tempOverReg = 1'b1;
        bypassReactivated = 1'b1;
        cyc(1);
        tempOverReg = 1'b0;
        bypassReactivated = 1'b0;
        for (int i = 0; i < 2000; i++) begin
            nT += (thermalHold_q === 1'b1) ? 1 : 0;
            nA += (attachEvalEnable_q === 1'b0) ? 1 : 0;
            cyc(1);
        end
        chkRange("thermalHold", 399 * TICK, 400 * TICK + 2, nT);
        chkRange("attachSettle", 399 * TICK, 400 * TICK + 2, nA);
        tallyAndFinish();
    end
    initial begin
        #(20000 * 100);
        errTotal++;
        tallyAndFinish();
    end
endmodule
`default_nettype wire
